// >>> cal_consts.svh
// timing counts, register offsets, field positions and reset values for the calibration control
// assumes the includer is a module or package of the calibration control block
`ifndef CAL_CONSTS_SVH
`define CAL_CONSTS_SVH
`define CAL_LOW_HOLD_CYCLES    16'h0100
`define CAL_HIGH_HOLD_CYCLES   16'h0100
`define CAL_SHORT_DELAY_CYCLES 32'h0000_1000
`define CAL_LONG_DELAY_CYCLES  32'h0004_0000
`define CAL_TRIM_CYCLES        16'h0400
`define CAL_CONV_CYCLES        16'h0800
`define CAL_REG_CONTROL        4'h0
`define CAL_REG_TRIM           4'h9
`define CAL_BIT_REQUEST        15
`define CAL_BIT_TRIM_DISABLE   0
`define CAL_BIT_SECOND_CLOCK   1
`define CAL_REG_RESET          16'h0000
`define CAL_CODE_MIN           10'sh000
`define CAL_CODE_MAX           10'sh0FF
`endif

// >>> cal_pkg.sv
// types used by the device end of the calibration control link
// assumes cal_consts.svh is on the include path
package cal_pkg;
  typedef enum {
    CAL_DELAY, CAL_HOLD_OFF, CAL_IDLE, CAL_TRIM, CAL_CONVERT
  } cal_state_type;
  typedef logic [15:0] reg_word_type;
endpackage : cal_pkg

// >>> cal_link_if.sv
// pins between the converter control and the host controller
// assumes one shared clock and synchronous reset supplied by the testbench
`timescale 1ns/10ps
interface cal_link_if (
  input wire logic clock,
  input wire logic srst
);
  logic       calibrateRequest;
  logic       calibrationDelaySelect;
  logic       extendedMode;
  logic       powerDownPin;
  logic       fullScaleSelect;
  logic       regWrite;
  logic [3:0] regAddr;
  logic [15:0] regData;
  logic       calibrationActive;
  logic       outOfRangeP;
  logic       outOfRangeN;
  logic       outputDataClock;
  logic       analogPoweredDown;
  modport device (
    input  clock, srst, calibrateRequest, calibrationDelaySelect, extendedMode,
           powerDownPin, fullScaleSelect, regWrite, regAddr, regData,
    output calibrationActive, outOfRangeP, outOfRangeN, outputDataClock,
           analogPoweredDown
  );
  modport host (
    input  clock, srst, calibrationActive, outOfRangeP, outOfRangeN,
           outputDataClock, analogPoweredDown,
    output calibrateRequest, calibrationDelaySelect, extendedMode, powerDownPin,
           fullScaleSelect, regWrite, regAddr, regData
  );
endinterface : cal_link_if

// >>> converter_calibration_control.sv
// device end: power-up and on-command calibration sequencer, range flag, full-scale select
// assumes clock is the converter's input sample clock and srst is power-on reset
//
// Contract
// - flag high while either result clips
// - second clock replaces range flag when enabled
// - pin picks range, or adjust register extended
// - calibrate automatically after power-up
// - pin and register bit request identically
// - same sequence whatever the clock start
// - calibration active high exactly during calibration
// - data clock stops unless trim disabled
// - command calibration trims unless trim disabled
// - power-up delay chosen by delay select
// - request high at power-up skips calibration
// - host holds request low then high
// - start after high hold, reject short pulses
// - analog held down until clock runs
// - power-down at power-up stops delay counter
// - extended mode always uses short delay
// - host waits for calibration active low
// - host recalibrates after twenty seconds, temperature; the host here recalibrates only on startCal
// - power-down during calibration waits for finish
// - requests ignored while powered down
`timescale 1ns/10ps
`include "cal_consts.svh"
module converter_calibration_control (
  // link to the host
  cal_link_if.device link,
  // converter results and adjust
  input  wire logic signed [9:0] resultI,
  input  wire logic signed [9:0] resultQ,
  input  wire logic        [7:0] fullScaleAdjust,
  input  wire logic              secondClockIn,
  // to the analog core
  output logic                   reducedRange,
  output logic             [7:0] rangeSetting,
  output logic                   coreInPowerDown
);
  cal_pkg::cal_state_type state;
  cal_pkg::reg_word_type  calControl;
  cal_pkg::reg_word_type  trimControl;
  logic [31:0] delayCount;
  logic [15:0] lowCount;
  logic [15:0] highCount;
  logic [15:0] stepCount;
  logic        lowQualified;
  logic        requestLevel;
  logic        commandPulse;
  logic        trimDisable;
  logic        powerUpDone;
  logic        clockSeen;

  // clips outside the 8-bit code range
  function automatic logic clipped(input logic signed [9:0] value);
    return (value < `CAL_CODE_MIN) || (value > `CAL_CODE_MAX);
  endfunction : clipped

  // register writes; the request bit self-clears after one cycle
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      calControl  <= `CAL_REG_RESET;
      trimControl <= `CAL_REG_RESET;
    end else begin
      calControl[`CAL_BIT_REQUEST] <= 1'b0;
      if (link.regWrite && link.regAddr == `CAL_REG_CONTROL) begin
        calControl <= link.regData;
      end
      if (link.regWrite && link.regAddr == `CAL_REG_TRIM && link.extendedMode) begin
        trimControl <= link.regData;
      end
    end
  end

  assign trimDisable  = link.extendedMode && trimControl[`CAL_BIT_TRIM_DISABLE];
  // register bit acts as a pin level; a write of the bit counts at once, like the pin
  assign requestLevel = link.calibrateRequest | calControl[`CAL_BIT_REQUEST]
                        | (link.regWrite && link.regAddr == `CAL_REG_CONTROL
                           && link.regData[`CAL_BIT_REQUEST]);

  // request qualification: low hold, then high hold
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      lowCount     <= 16'h0000;
      highCount    <= 16'h0000;
      lowQualified <= 1'b0;
    end else if (link.powerDownPin) begin
      lowCount     <= 16'h0000;
      highCount    <= 16'h0000;
      lowQualified <= 1'b0;
    end else if (!requestLevel) begin
      highCount <= 16'h0000;
      if (lowCount < `CAL_LOW_HOLD_CYCLES) begin
        lowCount <= lowCount + 16'h0001;
      end else begin
        lowQualified <= 1'b1;
      end
    end else begin
      lowCount <= 16'h0000;
      if (!lowQualified) begin
        highCount <= 16'h0000; // short low pulse rejected
      end else if (highCount < `CAL_HIGH_HOLD_CYCLES) begin
        highCount <= highCount + 16'h0001;
      end else begin
        highCount    <= 16'h0000;
        lowQualified <= 1'b0;
      end
    end
  end

  // one-cycle start after the high hold is met
  assign commandPulse = lowQualified && !link.powerDownPin
                        && (highCount == `CAL_HIGH_HOLD_CYCLES)
                        && requestLevel;

  // any clock edge proves the clock runs
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      clockSeen <= 1'b0;
    end else begin
      clockSeen <= 1'b1;
    end
  end

  // calibration sequencer
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      state       <= cal_pkg::CAL_DELAY;
      delayCount  <= 32'h0000_0000;
      stepCount   <= 16'h0000;
      powerUpDone <= 1'b0;
    end else begin
      case (state)
        cal_pkg::CAL_DELAY: begin
          if (link.calibrateRequest && delayCount == 32'h0000_0000) begin
            state <= cal_pkg::CAL_IDLE;
          end else if (!link.powerDownPin) begin
            delayCount <= delayCount + 32'h0000_0001;
            if (delayCount + 32'h0000_0001 >=
                ((link.extendedMode || !link.calibrationDelaySelect)
                 ? `CAL_SHORT_DELAY_CYCLES : `CAL_LONG_DELAY_CYCLES)) begin
              state     <= cal_pkg::CAL_TRIM;
              stepCount <= 16'h0000;
            end
          end
        end
        cal_pkg::CAL_IDLE: begin
          if (commandPulse) begin
            state     <= trimDisable ? cal_pkg::CAL_CONVERT : cal_pkg::CAL_TRIM;
            stepCount <= 16'h0000;
          end
        end
        cal_pkg::CAL_TRIM: begin
          stepCount <= stepCount + 16'h0001;
          if (stepCount == `CAL_TRIM_CYCLES - 16'h0001) begin
            state     <= cal_pkg::CAL_CONVERT;
            stepCount <= 16'h0000;
          end
        end
        cal_pkg::CAL_CONVERT: begin
          stepCount <= stepCount + 16'h0001;
          if (stepCount == `CAL_CONV_CYCLES - 16'h0001) begin
            state       <= cal_pkg::CAL_IDLE; // power-down waits for this
            powerUpDone <= 1'b1;
          end
        end
        default: begin
          state <= cal_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // calibration active from start to final step
  assign link.calibrationActive = (state == cal_pkg::CAL_TRIM) || (state == cal_pkg::CAL_CONVERT);

  // power-down only honoured outside calibration; analog down until clock runs
  assign coreInPowerDown = !clockSeen
                           || (link.powerDownPin && !link.calibrationActive);
  assign link.analogPoweredDown = coreInPowerDown;

  // data clock gated during calibration unless trim skipped
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      link.outputDataClock <= 1'b0;
    end else if (link.calibrationActive && !trimDisable) begin
      link.outputDataClock <= 1'b0;
    end else begin
      link.outputDataClock <= !link.outputDataClock;
    end
  end

  // range flag or second clock on the same pair
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      link.outOfRangeP <= 1'b0;
      link.outOfRangeN <= 1'b1;
    end else if (link.extendedMode && trimControl[`CAL_BIT_SECOND_CLOCK]) begin
      link.outOfRangeP <= secondClockIn;
      link.outOfRangeN <= !secondClockIn;
    end else begin
      link.outOfRangeP <= clipped(resultI) || clipped(resultQ);
      link.outOfRangeN <= !(clipped(resultI) || clipped(resultQ));
    end
  end

  // full-scale range selection
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      reducedRange <= 1'b0;
      rangeSetting <= 8'h00;
    end else if (link.extendedMode) begin
      reducedRange <= 1'b0;
      rangeSetting <= fullScaleAdjust;
    end else begin
      reducedRange <= !link.fullScaleSelect;
      rangeSetting <= 8'h00;
    end
  end
endmodule : converter_calibration_control

// >>> cal_host_control.sv
// host end: drives control pins, forms qualified calibration requests, watches completion
// assumes the same clock and synchronous reset as the converter
`timescale 1ns/10ps
`include "cal_consts.svh"
module cal_host_control (
  // link to the converter
  cal_link_if.host link,
  // user side
  input  wire logic        startCal,
  input  wire logic        useRegister,
  input  wire logic        delaySelect,
  input  wire logic        extended,
  input  wire logic        powerDown,
  input  wire logic        fullScale,
  input  wire logic        trimWrite,
  input  wire logic [15:0] trimValue,
  output logic             calBusy,
  output logic             calDone,
  output logic             rangeAlarm
);
  logic [15:0] holdCount;
  logic        phaseHigh;
  logic        pending;
  logic        wasActive;

  // static control pins
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      link.calibrationDelaySelect <= 1'b0;
      link.extendedMode           <= 1'b0;
      link.powerDownPin           <= 1'b0;
      link.fullScaleSelect        <= 1'b1;
    end else begin
      link.calibrationDelaySelect <= delaySelect;
      link.extendedMode           <= extended;
      link.powerDownPin           <= powerDown;
      link.fullScaleSelect        <= fullScale;
    end
  end

  // request: low hold, then high hold on pin or register bit
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      holdCount <= 16'h0000;
      phaseHigh <= 1'b0;
      pending   <= 1'b0;
      link.calibrateRequest <= startCal; // request held through power-up
      link.regWrite <= 1'b0;
      link.regAddr  <= 4'h0;
      link.regData  <= 16'h0000;
    end else begin
      link.regWrite <= 1'b0;
      if (!pending) begin
        link.calibrateRequest <= 1'b0;
        if (trimWrite) begin
          link.regWrite <= 1'b1; // trim and second clock settings
          link.regAddr  <= `CAL_REG_TRIM;
          link.regData  <= trimValue;
        end
        if (startCal) begin
          pending   <= 1'b1;
          phaseHigh <= 1'b0;
          holdCount <= 16'h0000;
        end
      end else if (!phaseHigh) begin
        holdCount <= holdCount + 16'h0001;
        if (holdCount == `CAL_LOW_HOLD_CYCLES + 16'h0001) begin
          phaseHigh <= 1'b1;
          holdCount <= 16'h0000;
        end
      end else begin
        holdCount <= holdCount + 16'h0001;
        if (useRegister) begin
          link.regWrite <= 1'b1;
          link.regAddr  <= `CAL_REG_CONTROL;
          link.regData  <= 16'h8000;
        end else begin
          link.calibrateRequest <= 1'b1;
        end
        if (holdCount == `CAL_HIGH_HOLD_CYCLES + 16'h0001) begin
          pending <= 1'b0;
        end
      end
    end
  end

  // completion seen on falling calibration active
  always_ff @(posedge link.clock) begin
    if (link.srst) begin
      wasActive  <= 1'b0;
      calDone    <= 1'b0;
      calBusy    <= 1'b0;
      rangeAlarm <= 1'b0;
    end else begin
      wasActive  <= link.calibrationActive;
      calDone    <= wasActive && !link.calibrationActive;
      calBusy    <= link.calibrationActive;
      rangeAlarm <= link.outOfRangeP && !link.outOfRangeN;
    end
  end
endmodule : cal_host_control

// >>> cal_link_assertions.sv
// concurrent checks on the calibration link between converter and host
// assumes the testbench feeds it the link signals and the shared clock and reset
`timescale 1ns/10ps
module cal_link_assertions (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // host pins
  input wire logic        calibrateRequest,
  input wire logic        calibrationDelaySelect,
  input wire logic        extendedMode,
  input wire logic        powerDownPin,
  input wire logic        regWrite,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regData,
  // device pins
  input wire logic        calibrationActive,
  input wire logic        outOfRangeP,
  input wire logic        outOfRangeN,
  input wire logic        outputDataClock
);
  logic        reqHigh;
  logic        prevHigh;
  logic        firstDone;
  logic        trimOff;
  logic [15:0] highCnt;
  logic [15:0] activeCnt;
  logic [19:0] upCnt;
  // request level from the pin or a write of the request bit
  assign reqHigh = calibrateRequest | (regWrite & (regAddr == 4'h0) & regData[15]);
  // length of the latest high run of the request
  always_ff @(posedge clock) begin
    prevHigh <= reqHigh & ~srst;
    if (srst) highCnt <= 16'h0000;
    else if (reqHigh && !prevHigh) highCnt <= 16'h0001;
    else if (reqHigh && highCnt != 16'hFFFF) highCnt <= highCnt + 16'h0001;
  end
  // cycles spent in the current calibration
  always_ff @(posedge clock) begin
    if (srst || !calibrationActive) activeCnt <= 16'h0000;
    else activeCnt <= activeCnt + 16'h0001;
  end
  // power-up delay cycles, frozen while powered down
  always_ff @(posedge clock) begin
    if (srst) upCnt <= 20'h00000;
    else if (!powerDownPin && upCnt != 20'hFFFFF) upCnt <= upCnt + 20'h00001;
  end
  // trim disable bit as written in extended mode
  always_ff @(posedge clock) begin
    if (srst) trimOff <= 1'h0;
    else if (regWrite && regAddr == 4'h9 && extendedMode) trimOff <= regData[0];
  end
  // marks the end of the first calibration
  always_ff @(posedge clock) begin
    if (srst) firstDone <= 1'h0;
    else if (activeCnt != 16'h0000 && !calibrationActive) firstDone <= 1'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_range_legs; outOfRangeP != outOfRangeN; endproperty
  a_range_legs: assert property (p_range_legs) else $error("range legs equal");
  property p_clk_held;
    calibrationActive && $past(calibrationActive) && !(trimOff && extendedMode)
      |-> !outputDataClock;
  endproperty
  a_clk_held: assert property (p_clk_held) else $error("data clock ran in calibration");
  property p_clk_runs;
    !calibrationActive && !$past(calibrationActive) && !powerDownPin && !$past(powerDownPin)
      && !$past(srst) |-> outputDataClock != $past(outputDataClock);
  endproperty
  a_clk_runs: assert property (p_clk_runs) else $error("data clock stopped");
  property p_cmd_start; $rose(calibrationActive) && firstDone |-> highCnt >= 16'h0100;
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("start without request");
  property p_pd_hold; powerDownPin && !calibrationActive |=> !calibrationActive; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("start while powered down");
  property p_len;
    $fell(calibrationActive) |-> activeCnt == 16'h0C00 || activeCnt == 16'h0800;
  endproperty
  a_len: assert property (p_len) else $error("wrong calibration length");
  property p_len_max; activeCnt <= 16'h0C00; endproperty
  a_len_max: assert property (p_len_max) else $error("calibration too long");
  property p_delay;
    $rose(calibrationActive) && !firstDone && highCnt == 16'h0000 |->
      ((calibrationDelaySelect && !extendedMode) ? upCnt >= 20'h40000 :
       (upCnt >= 20'h00FFF && upCnt <= 20'h01008));
  endproperty
  a_delay: assert property (p_delay) else $error("wrong power-up delay");
  // main scenarios
  c_cmd: cover property ($rose(calibrationActive) && firstDone);
  c_pd_end: cover property ($fell(calibrationActive) && powerDownPin);
  c_clip: cover property (outOfRangeP);
  c_reg: cover property (regWrite && regData[15]);
  c_trim: cover property (calibrationActive && trimOff && extendedMode);
endmodule : cal_link_assertions

// >>> testbench.sv
// self-checking bench: converter and host joined by the link, user sides driven here
// assumes the design files and the link checker are compiled before it
`timescale 1ns/10ps
module testbench;
  typedef struct {
    logic signed [9:0] resI;
    logic signed [9:0] resQ;
    logic              ext;
    logic              fs;
    logic        [7:0] adj;
    logic              clip;
  } row_type;
  logic              clock = 1'h0;
  logic              srst = 1'h1;
  logic              startCal, useRegister, delaySelect, extended, powerDown, fullScale;
  logic              trimWrite, secondClock;
  logic       [15:0] trimValue;
  logic signed [9:0] resultI, resultQ;
  logic        [7:0] fullScaleAdjust, rangeSetting;
  logic              reducedRange, calBusy, calDone, rangeAlarm, doneSeen;
  int                err_total, num_checks, cnt, lat0, lat1;
  row_type           rows [6] = '{
    '{10'sh000, 10'sh000, 1'h0, 1'h1, 8'h00, 1'h0}, '{10'sh0FF, 10'sh0FF, 1'h0, 1'h0, 8'h00, 1'h0},
    '{10'sh100, 10'sh000, 1'h0, 1'h1, 8'h00, 1'h1}, '{10'sh000, 10'sh3FF, 1'h1, 1'h0, 8'h5A, 1'h1},
    '{10'sh200, 10'sh080, 1'h1, 1'h1, 8'hA5, 1'h1}, '{10'sh080, 10'sh1FF, 1'h0, 1'h0, 8'h00, 1'h1}};
  cal_link_if u_link (.clock(clock), .srst(srst));
  converter_calibration_control u_converter_calibration_control (.link(u_link),
    .resultI(resultI), .resultQ(resultQ), .fullScaleAdjust(fullScaleAdjust),
    .secondClockIn(secondClock), .reducedRange(reducedRange), .rangeSetting(rangeSetting),
    .coreInPowerDown());
  cal_host_control u_cal_host_control (.link(u_link), .startCal(startCal),
    .useRegister(useRegister), .delaySelect(delaySelect), .extended(extended),
    .powerDown(powerDown), .fullScale(fullScale), .calBusy(calBusy), .calDone(calDone),
    .rangeAlarm(rangeAlarm), .trimWrite(trimWrite), .trimValue(trimValue));
  cal_link_assertions u_cal_link_assertions (.clock(clock), .srst(srst),
    .calibrateRequest(u_link.calibrateRequest), .calibrationDelaySelect(u_link.calibrationDelaySelect),
    .extendedMode(u_link.extendedMode), .powerDownPin(u_link.powerDownPin),
    .regWrite(u_link.regWrite), .regAddr(u_link.regAddr), .regData(u_link.regData),
    .calibrationActive(u_link.calibrationActive), .outOfRangeP(u_link.outOfRangeP),
    .outOfRangeN(u_link.outOfRangeN), .outputDataClock(u_link.outputDataClock));
  // clock generator
  always #20 clock = ~clock;
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // wait, bounded, until calibration active reaches a level
  task automatic follow(output int c, input logic lvl, input int lim);
    c = 0;
    while (u_link.calibrationActive !== lvl && c < lim) begin
      @(negedge clock);
      c++;
      doneSeen |= (calDone === 1'h1);
    end
  endtask : follow
  // one command calibration, power-down optionally raised once it runs
  task automatic run_cal(input logic viaReg, input logic pdMid, input int expLen, output int lat);
    int   len;
    logic output_data_clock;
    useRegister = viaReg;
    startCal = 1'h1;
    @(negedge clock);
    startCal = 1'h0;
    doneSeen = 1'h0;
    follow(lat, 1'h1, 1024);
    powerDown = pdMid;
    @(negedge clock);
    check("busy", calBusy, 1'h1);
    check("pd_during", u_link.analogPoweredDown, 1'h0);
    output_data_clock = u_link.outputDataClock;
    @(negedge clock);
    check("data_clock", 32'(u_link.outputDataClock != output_data_clock), 32'(expLen == 2048));
    follow(len, 1'h0, 8192);
    repeat (3) @(negedge clock) doneSeen |= (calDone === 1'h1);
    check("cal_len", len + 2, expLen);
    check("done", doneSeen, 1'h1);
    check("pd_after", u_link.analogPoweredDown, pdMid);
    powerDown = 1'h0;
    repeat (16) @(negedge clock);
  endtask : run_cal
  // reset with request and power-down levels set up front
  task automatic power_up(input logic req, input logic pd);
    srst = 1'h1;
    {startCal, powerDown} = {req, pd};
    repeat (5) @(negedge clock);
    srst = 1'h0;
  endtask : power_up
  // watchdog, well beyond the roughly 34000 cycles that the tests take
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    {startCal, useRegister, powerDown} = 3'h0;
    {delaySelect, extended, fullScale} = 3'h7;
    {resultI, resultQ, fullScaleAdjust} = 28'h0;
    {trimWrite, secondClock, trimValue} = 18'h0;
    repeat (5) @(negedge clock);
    srst = 1'h0;
    check("active_rst", u_link.calibrationActive, 1'h0);
    check("range_rst", u_link.outOfRangeN, 1'h1);
    check("analog_rst", u_link.analogPoweredDown, 1'h1);
    follow(cnt, 1'h1, 8192);
    check("pwr_delay", 32'(cnt >= 4095 && cnt <= 4104), 1'h1);
    check("analog_run", u_link.analogPoweredDown, 1'h0);
    follow(cnt, 1'h0, 8192);
    check("pwr_len", cnt, 32'h0C00);
    $display("power-up calibration test ended");
    foreach (rows[i]) begin
      {resultI, resultQ, extended} = {rows[i].resI, rows[i].resQ, rows[i].ext};
      {fullScale, fullScaleAdjust} = {rows[i].fs, rows[i].adj};
      repeat (4) @(negedge clock);
      check("range_p", u_link.outOfRangeP, rows[i].clip);
      check("range_n", u_link.outOfRangeN, !rows[i].clip);
      check("alarm", rangeAlarm, rows[i].clip);
      if (rows[i].ext) check("adjust", rangeSetting, rows[i].adj);
      else check("reduced", reducedRange, !rows[i].fs);
    end
    $display("range and full-scale table test ended");
    run_cal(1'h0, 1'h0, 3072, lat0);
    run_cal(1'h1, 1'h0, 3072, lat1);
    check("same_path", lat1, lat0);
    check("cmd_latency", 32'(lat0 >= 256 && lat0 <= 600), 1'h1);
    $display("pin and register calibration test ended");
    powerDown = 1'h1;
    repeat (8) @(negedge clock);
    startCal = 1'h1;
    @(negedge clock);
    startCal = 1'h0;
    follow(cnt, 1'h1, 1024);
    check("pd_refuse", u_link.calibrationActive, 1'h0);
    powerDown = 1'h0;
    follow(cnt, 1'h1, 1024);
    check("pd_later", u_link.calibrationActive, 1'h0);
    run_cal(1'h0, 1'h1, 3072, lat0);
    $display("power-down calibration test ended");
    extended = 1'h1;
    trimValue = 16'h0003;
    trimWrite = 1'h1;
    @(negedge clock);
    trimWrite = 1'h0;
    secondClock = 1'h1;
    repeat (4) @(negedge clock);
    check("second_clk_hi", u_link.outOfRangeP, 1'h1);
    secondClock = 1'h0;
    repeat (2) @(negedge clock);
    check("second_clk_lo", u_link.outOfRangeP, 1'h0);
    run_cal(1'h0, 1'h0, 2048, lat1);
    $display("trim disable and second clock test ended");
    {delaySelect, extended} = 2'h0;
    power_up(1'h0, 1'h1);
    repeat (64) @(negedge clock);
    powerDown = 1'h0;
    follow(cnt, 1'h1, 8192);
    check("pd_delay", 32'(cnt >= 4095 && cnt <= 4104), 1'h1);
    follow(cnt, 1'h0, 8192);
    check("pd_len", cnt, 32'h0C00);
    $display("power-down at power-up test ended");
    power_up(1'h1, 1'h0);
    @(negedge clock);
    startCal = 1'h0;
    follow(cnt, 1'h1, 8192);
    check("held_req", 32'(cnt >= 256 && cnt <= 600), 1'h1);
    follow(cnt, 1'h0, 8192);
    check("held_len", cnt, 32'h0C00);
    $display("request held at power-up test ended");
    complete_run();
  end
endmodule : testbench
